/* File: verilog/adcsb_serial.sv */
// Top of the converter serial port: link shifter, crossings, output drive
`timescale 1ns/1ps
module adcsb_serial #(
    parameter int CONV_CYCLES = adcsb_pkg::CONV_CYC
) (
    // System clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // Serial link
    input  wire logic                       sck,
    input  wire logic                       convert_strobe,
    input  wire logic                       serial_in,
    output logic                            serial_out,
    output logic                            serial_out_oe,
    // Converter core side
    input  wire logic [adcsb_pkg::RES_W-1:0] sample_in,
    output logic      [adcsb_pkg::CFG_W-1:0] config_out,
    output logic                            converter_on
);
    import adcsb_pkg::*;

    adcsb_conv_if cif ();

    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    // Falling edge that releases the output for the current mode
    function automatic logic [CNT_W-1:0] release_edge(
        input logic busy,
        input logic rb
    );
        if (busy) begin
            release_edge = rb ? REL_BUSY_RB : REL_BUSY;
        end else begin
            release_edge = rb ? REL_NB_RB : REL_NB;
        end
    endfunction

    // Bit of the result-then-config stream at a position, MSB first
    function automatic logic stream_bit(
        input logic [STREAM_W-1:0] s,
        input logic [CNT_W-1:0]    i
    );
        if (int'(i) < STREAM_W) begin
            stream_bit = s[STREAM_W - 1 - int'(i)];
        end else begin
            stream_bit = 1'b0;
        end
    endfunction

    //--------------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------------
    logic                frame_clr;
    logic [CNT_W-1:0]    fcnt_ff, nxt_fcnt;
    logic [3:0]          rcnt_ff, nxt_rcnt;
    logic [CFG_W-1:0]    shift_ff, nxt_shift;
    logic [CFG_W-1:0]    hold_ff;
    logic                tog_ff;
    logic                cfg_open, cfg_last;
    logic                gate_ff;
    logic                cnv_s, cnv_d_ff;
    logic                tog_s, tog_d_ff;
    logic                busy, rb;
    logic [CNT_W-1:0]    lim, idx;
    logic [STREAM_W-1:0] stream;
    logic                ready_low;
    logic                link_bit, link_oe;

    //--------------------------------------------------------------------------
    // Link domain: falling-edge counter
    //--------------------------------------------------------------------------
    // Strobe high holds the link counters and shifter cleared, so input is ignored
    assign frame_clr = ~reset_n | convert_strobe;
    assign nxt_fcnt  = (fcnt_ff == FALL_CNT_MAX) ?
                       fcnt_ff : fcnt_ff + 5'h01;

    // Counts falling edges within the transfer
    always_ff @(negedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            fcnt_ff <= '0;
        end else begin
            fcnt_ff <= nxt_fcnt;
        end
    end

    //--------------------------------------------------------------------------
    // Link domain: configuration shift-in
    //--------------------------------------------------------------------------
    // Only the first fourteen rising edges shift, then the word is closed
    assign cfg_open  = (rcnt_ff < CFG_RISE_N);
    assign cfg_last  = cfg_open && (rcnt_ff == CFG_RISE_LAST);
    assign nxt_rcnt  = cfg_open ? rcnt_ff + 4'h1 : rcnt_ff;
    assign nxt_shift = cfg_open ?
                       {shift_ff[CFG_W-2:0], serial_in} : shift_ff;

    // Counter and shifter restart with every transfer
    always_ff @(posedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            rcnt_ff  <= '0;
            shift_ff <= CFG_RESET;
        end else begin
            rcnt_ff  <= nxt_rcnt;
            shift_ff <= nxt_shift;
        end
    end

    // A complete word is held and announced by a toggle
    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            hold_ff <= CFG_RESET;
            tog_ff  <= 1'b0;
        end else if (cfg_last) begin
            hold_ff <= nxt_shift;
            tog_ff  <= ~tog_ff;
        end
    end

    //--------------------------------------------------------------------------
    // System domain: crossings
    //--------------------------------------------------------------------------
    adcsb_sync #(
        .W (2)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({convert_strobe, tog_ff}),
        .q       ({cnv_s, tog_s})
    );

    // Edge history for the synchronised strobe and toggle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnv_d_ff <= 1'b0;
            tog_d_ff <= 1'b0;
        end else begin
            cnv_d_ff <= cnv_s;
            tog_d_ff <= tog_s;
        end
    end

    // Strobe rise starts a conversion; word is stable before its toggle
    assign cif.start    = cnv_s & ~cnv_d_ff;
    assign cif.cnv_low  = ~cnv_s;
    assign cif.cfg_new  = tog_s ^ tog_d_ff;
    assign cif.cfg_word = hold_ff;
    assign cif.sample   = sample_in;

    adcsb_conv #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_conv (
        .clk     (clk),
        .reset_n (reset_n),
        .cif     (cif)
    );

    //--------------------------------------------------------------------------
    // Output gate
    //--------------------------------------------------------------------------
    // Drops the drive at once on a strobe rise, reopens a cycle after it falls
    always_ff @(posedge clk or posedge frame_clr) begin
        if (frame_clr) begin
            gate_ff <= 1'b0;
        end else begin
            gate_ff <= 1'b1;
        end
    end

    //--------------------------------------------------------------------------
    // Serial output
    //--------------------------------------------------------------------------
    // Result and config change only at conversion end, mode also clears at start; never mid-read
    assign busy      = cif.busy_mode;
    assign rb        = cif.result_cfg[CFG_RB_BIT];
    assign stream    = {cif.result, cif.result_cfg};
    assign lim       = release_edge(busy, rb);
    assign ready_low = busy && (fcnt_ff == '0);
    // Ready mode starts the result one edge later, after the low marker
    assign idx       = busy ? fcnt_ff - 5'h01 : fcnt_ff;
    assign link_bit  = ready_low ? 1'b0 : stream_bit(stream, idx);
    assign link_oe   = cif.conv_done && (fcnt_ff < lim);

    // Pin drive; while enabled, the bit changes only on falling edges of the serial clock
    assign serial_out    = link_bit;
    assign serial_out_oe = gate_ff & link_oe;

    // Converter-side outputs come from sequencer registers
    assign config_out    = cif.cfg_active;
    assign converter_on  = cif.powered;

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    sequence s_frame_open;
        cif.conv_done && !convert_strobe;
    endsequence

    chk_nb_result_lsb: assert property (
        @(negedge sck) disable iff (frame_clr)
        (s_frame_open and (!busy && fcnt_ff == LSB_FALL_NB)) |->
        (link_bit == cif.result[0] && link_oe))
        else $error("result LSB missing at fifteenth falling edge");
    chk_nb_cfg_lsb: assert property (
        @(negedge sck) disable iff (frame_clr)
        (s_frame_open and (!busy && rb && fcnt_ff == CFG_LSB_NB)) |->
        (link_bit == cif.result_cfg[0] && link_oe))
        else $error("config LSB missing at twenty-ninth edge");
    chk_nb_release: assert property (
        @(posedge clk) disable iff (frame_clr)
        (!busy && fcnt_ff >= (rb ? REL_NB_RB : REL_NB)) |-> !serial_out_oe)
        else $error("output not released after last counted edge");
    chk_busy_result_lsb: assert property (
        @(negedge sck) disable iff (frame_clr)
        (s_frame_open and (busy && fcnt_ff == LSB_FALL_BUSY)) |->
        (link_bit == cif.result[0]))
        else $error("ready mode result LSB not at sixteenth edge");
    chk_busy_cfg_lsb: assert property (
        @(negedge sck) disable iff (frame_clr)
        (s_frame_open and (busy && rb && fcnt_ff == CFG_LSB_BUSY)) |->
        (link_bit == cif.result_cfg[0] && link_oe))
        else $error("ready mode config LSB not at thirtieth edge");
    chk_busy_release: assert property (
        @(posedge clk) disable iff (frame_clr)
        (busy && fcnt_ff >= (rb ? REL_BUSY_RB : REL_BUSY)) |->
        !serial_out_oe)
        else $error("ready mode output still driven after release edge");
    chk_busy_marker: assert property (
        @(posedge clk) disable iff (frame_clr)
        (busy && cif.conv_done && fcnt_ff == '0 && gate_ff) |->
        (serial_out_oe && !serial_out))
        else $error("ready marker not driven low");
    chk_msb_first: assert property (
        @(negedge sck) disable iff (frame_clr)
        (s_frame_open and (!busy && fcnt_ff == '0)) |->
        (link_bit == cif.result[RES_W-1]))
        else $error("result MSB not shown first");
    chk_strobe_release: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(convert_strobe) |-> !serial_out_oe)
        else $error("output driven after strobe rise");
endmodule // adcsb_serial

/* File: shared/adcsb_pkg.sv */
// Constants and types for the converter serial port with data-ready output
//------------------------------------------------------------------------------
// Overview of operation
// - No-ready mode: result LSB by 15th fall
// - No-ready readback: config LSB by 29th fall
// - No-ready mode: release output at 16/30
// - Strobe rise: convert, ignore input, release output
// - Started conversion always runs to its end
// - End of conversion, strobe low: drive low
// - After conversion: acquire, converter powered down
// - Config in, result out in one transfer
// - Config sampled on first fourteen rising edges
// - Ready mode: result MSB first, sixteen falls
// - Partial config word discarded, old one stays
// - Unread result lost at next conversion end
// - Output bits held stable between falling edges
// - Ready mode: release output at 17/31
// - Readback config follows result LSB, MSB first
// - Ready readback: config LSB by 30th fall
// - Without release edge, last bit stays driven
// - No-ready mode: MSB shown when strobe low
// - No-ready: fifteen falls shift remaining bits
// - No-ready: strobe rise releases output early
//------------------------------------------------------------------------------
package adcsb_pkg;

    // Word widths
    localparam int RES_W    = 16;
    localparam int CFG_W    = 14;
    localparam int STREAM_W = RES_W + CFG_W;
    localparam int CNT_W    = 5;

    // Falling-edge counts on the serial clock
    localparam logic [4:0] LSB_FALL_NB    = 5'h0F;
    localparam logic [4:0] CFG_LSB_NB     = 5'h1D;
    localparam logic [4:0] LSB_FALL_BUSY  = 5'h10;
    localparam logic [4:0] CFG_LSB_BUSY   = 5'h1E;
    localparam logic [4:0] REL_NB         = 5'h10;
    localparam logic [4:0] REL_NB_RB      = 5'h1E;
    localparam logic [4:0] REL_BUSY       = 5'h11;
    localparam logic [4:0] REL_BUSY_RB    = 5'h1F;
    localparam logic [4:0] FALL_CNT_MAX   = 5'h1F;

    // Rising-edge counts for the configuration word
    localparam logic [3:0] CFG_RISE_N     = 4'hE;
    localparam logic [3:0] CFG_RISE_LAST  = 4'hD;

    // Configuration layout and reset value
    localparam int          CFG_RB_BIT = 0;
    localparam logic [13:0] CFG_RESET  = 14'h0000;

    // Conversion timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int CONV_TIME_NS    = 2200;
    localparam int CONV_CYC        =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Converter phase
    typedef enum logic [0:0] {
        ADCSB_ACQ  = 1'b0,
        ADCSB_CONV = 1'b1
    } adcsb_state_t;

endpackage

/* File: shared/adcsb_conv_if.sv */
// Carrier between the serial port top and the conversion sequencer
`timescale 1ns/1ps
interface adcsb_conv_if;
    import adcsb_pkg::*;
    logic              start;
    logic              cnv_low;
    logic              cfg_new;
    logic [CFG_W-1:0]  cfg_word;
    logic [RES_W-1:0]  sample;
    logic [RES_W-1:0]  result;
    logic [CFG_W-1:0]  result_cfg;
    logic [CFG_W-1:0]  cfg_active;
    logic              busy_mode;
    logic              conv_done;
    logic              powered;

    modport conv (
        input  start, cnv_low, cfg_new, cfg_word, sample,
        output result, result_cfg, cfg_active, busy_mode, conv_done, powered
    );
    modport top (
        output start, cnv_low, cfg_new, cfg_word, sample,
        input  result, result_cfg, cfg_active, busy_mode, conv_done, powered
    );
endinterface

/* File: verilog/adcsb_sync.sv */
// Two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
module adcsb_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule // adcsb_sync

/* File: verilog/adcsb_conv.sv */
// Conversion sequencer: timing, power state, result and configuration
`timescale 1ns/1ps
module adcsb_conv #(
    parameter int CONV_CYCLES = adcsb_pkg::CONV_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Link to the serial port top
    adcsb_conv_if.conv cif
);
    import adcsb_pkg::*;

    localparam int           CW       = $clog2(CONV_CYCLES + 1);
    localparam logic [CW-1:0] LAST    = CW'(CONV_CYCLES - 1);
    localparam int           CONV_DLY = CONV_CYCLES;

    adcsb_state_t     state_ff, nxt_state;
    logic [CW-1:0]    cnt_ff, nxt_cnt;
    logic [RES_W-1:0] result_ff;
    logic [CFG_W-1:0] rcfg_ff, cfg_ff, pend_ff;
    logic             pend_vld_ff, busy_ff, done_ff, pwr_ff;
    logic             take_start, eoc;

    //--------------------------------------------------------------------------
    // Phase decode
    //--------------------------------------------------------------------------
    // Strobes during a conversion are ignored
    assign take_start = cif.start && (state_ff == ADCSB_ACQ);
    assign eoc        = (state_ff == ADCSB_CONV) && (cnt_ff == LAST);
    assign nxt_state  = take_start ? ADCSB_CONV :
                        (eoc ? ADCSB_ACQ : state_ff);
    assign nxt_cnt    = (state_ff == ADCSB_CONV && !eoc) ?
                        cnt_ff + CW'(1) : '0;

    // Phase and timer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ADCSB_ACQ;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Pending word: a new arrival wins over the clear at conversion end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_ff     <= CFG_RESET;
            pend_vld_ff <= 1'b0;
        end else begin
            pend_ff     <= cif.cfg_new ? cif.cfg_word : pend_ff;
            pend_vld_ff <= cif.cfg_new | (pend_vld_ff & ~eoc);
        end
    end

    // Result, its configuration, and the applied configuration
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result_ff <= '0;
            rcfg_ff   <= CFG_RESET;
            cfg_ff    <= CFG_RESET;
        end else if (eoc) begin
            result_ff <= cif.sample;
            rcfg_ff   <= cfg_ff;
            cfg_ff    <= pend_vld_ff ? pend_ff : cfg_ff;
        end
    end

    // Ready mode, done flag and converter power
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            pwr_ff  <= 1'b0;
        end else if (take_start) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            pwr_ff  <= 1'b1;
        end else if (eoc) begin
            busy_ff <= cif.cnv_low;
            done_ff <= 1'b1;
            pwr_ff  <= 1'b0;
        end
    end

    assign cif.result     = result_ff;
    assign cif.result_cfg = rcfg_ff;
    assign cif.cfg_active = cfg_ff;
    assign cif.busy_mode  = busy_ff;
    assign cif.conv_done  = done_ff;
    assign cif.powered    = pwr_ff;

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    sequence s_start;
        cif.start && state_ff == ADCSB_ACQ;
    endsequence

    // Once running, only the timer end leaves the conversion phase
    chk_conv_runs_on: assert property (@(posedge clk) disable iff (!reset_n)
        (state_ff == ADCSB_CONV && !eoc) |=> (state_ff == ADCSB_CONV))
        else $error("conversion stopped early");
    chk_conv_end_time: assert property (@(posedge clk) disable iff (!reset_n)
        s_start |-> ##CONV_DLY eoc)
        else $error("conversion end not at the set time");
    chk_power_down: assert property (@(posedge clk) disable iff (!reset_n)
        eoc |=> (!pwr_ff && state_ff == ADCSB_ACQ && done_ff))
        else $error("converter not powered down after conversion");
    chk_cfg_kept: assert property (@(posedge clk) disable iff (!reset_n)
        (eoc && !pend_vld_ff) |=> $stable(cfg_ff))
        else $error("configuration changed without a full word");
    chk_cfg_applied: assert property (@(posedge clk) disable iff (!reset_n)
        (eoc && pend_vld_ff) |=> cfg_ff == $past(pend_ff))
        else $error("full configuration word not applied");
    chk_ready_mode: assert property (@(posedge clk) disable iff (!reset_n)
        eoc |=> busy_ff == $past(cif.cnv_low))
        else $error("ready mode not taken from strobe level");
endmodule // adcsb_conv

/* File: verif/adcsb_host.sv */
// Host model: frames the serial link with an idle-high clock
`timescale 1ns/1ps
module adcsb_host (
    // Serial link
    output logic        sck,
    output logic        serial_in,
    input  wire logic   line,
    input  wire logic   oe,
    // Captured frame
    output logic [30:0] got,
    output logic        oe_end,
    output logic        done
);
    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial begin
        sck = 1'b1;
        serial_in = 1'b0;
        got = '0;
        oe_end = 1'b0;
        done = 1'b0;
    end

    // One frame of nf falls; config MSB first on rising edges
    task automatic xfer(input int nf, input logic [13:0] cfg);
        got = '0;
        serial_in = cfg[13];
        #13;
        for (int k = 0; k < nf; k++) begin
            #20 got = {got[29:0], line};
            sck = 1'b0;
            #20 serial_in = (k < 14) ? cfg[13-k] : ~serial_in;
            #20 sck = 1'b1;
            #20;
        end
        oe_end = oe;
        done = ~done;
    endtask
endmodule // adcsb_host

/* File: verif/tb.sv */
// Self-checking bench for the converter serial port
`timescale 1ns/1ps
module tb;
    import adcsb_pkg::*;
    localparam int CONV_N = 4;
    logic                clk;
    logic                reset_n;
    logic                convert_strobe;
    logic [RES_W-1:0]    sample_in;
    wire logic          sck;
    wire logic          serial_in;
    wire logic          serial_out;
    wire logic          serial_out_oe;
    wire logic [CFG_W-1:0] config_out;
    wire logic          converter_on;
    wire logic          line;
    wire logic [30:0]   got;
    wire logic          oe_end;
    wire logic          done;
    logic [31:0]         seed;
    logic [31:0]         q[$];
    logic [15:0]         r;
    int                  fails;
    int                  n_tests;
    int                  cyc;

    // Wire with pull-up while released
    assign line = serial_out_oe ? serial_out : 1'b1;

    adcsb_serial #(.CONV_CYCLES(CONV_N)) dut_u (
        .clk(clk), .reset_n(reset_n), .sck(sck),
        .convert_strobe(convert_strobe), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .sample_in(sample_in), .config_out(config_out),
        .converter_on(converter_on)
    );
    adcsb_host host_u (
        .sck(sck), .serial_in(serial_in), .line(line),
        .oe(serial_out_oe), .got(got), .oe_end(oe_end), .done(done)
    );

    // ------------------------------------------------------------
    // Clock, helpers and verdict
    // ------------------------------------------------------------
    always #25 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        n_tests++;
        if (a !== e) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, a, e);
        end
    endtask

    // Frame results compared against the oldest note
    always @(done) begin
        if ($time > 0 && q.size() == 0)
            chk(32'hFFFFFFFF, 32'h0);
        else if ($time > 0)
            chk({oe_end, got}, q.pop_front());
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            close_out();
        end
    end

    // One conversion; ready leaves the strobe low at its end
    task automatic conv(input bit ready);
        seed = xs(seed);
        r = seed[15:0];
        @(posedge clk);
        convert_strobe <= 1'b1;
        sample_in <= r;
        #1 chk({31'h0, serial_out_oe}, 32'h0);
        if (ready) begin
            @(posedge clk) convert_strobe <= 1'b0;
            @(posedge clk) convert_strobe <= 1'b1;
            @(posedge clk) convert_strobe <= 1'b0;
        end
        repeat (ready ? 3 : 6) @(posedge clk);
        #1 chk({31'h0, converter_on}, 32'h1);
        repeat (14) @(posedge clk);
        #1 chk({31'h0, converter_on}, 32'h0);
        @(posedge clk);
        sample_in <= ~r;
        if (!ready)
            convert_strobe <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic frame(input int nf, input logic [13:0] c,
                         input logic [31:0] e);
        q.push_back(e);
        host_u.xfer(nf, c);
        #40;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        convert_strobe = 1'b0;
        sample_in = '0;
        seed = 32'h1E87FEE2;
        fails = 0;
        n_tests = 0;
        cyc = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        conv(1'b1);
        chk({18'h0, config_out}, 32'h0);
        frame(17, 14'h2A5B, {1'b0, 14'h0, 1'b0, r});
        conv(1'b1);
        chk({18'h0, config_out}, {18'h0, 14'h2A5B});
        conv(1'b1);
        frame(31, 14'h2A5B, {2'b0, r, 14'h2A5B});
        conv(1'b0);
        frame(30, 14'h1C36, {2'b0, r, 14'h2A5B});
        conv(1'b0);
        chk({18'h0, config_out}, {18'h0, 14'h1C36});
        frame(30, 14'h1C36, {2'b0, r, 14'h2A5B});
        conv(1'b0);
        frame(16, 14'h1C36, {16'h0, r});
        conv(1'b0);
        frame(10, 14'h3FFF, {1'b1, 21'h0, r[15:6]});
        conv(1'b1);
        chk({18'h0, config_out}, {18'h0, 14'h1C36});
        close_out();
    end
endmodule // tb
